/* File: verilog/fpd_top.sv */
// digital control of a fractional-N synthesizer: dividers, modulator, spread, stepping
// assumes an AXI4-Lite master on clk_sys and a pfd-rate tick from the analog side
//
// Contract
// - pfd rate is input over reference field; zero means doubling.
// - feedback integer ratio comes from the 15-bit divider field.
// - numerator is 8-bit upper field over 16-bit lower field.
// - denominator is built the same way; zero means two to the 24.
// - order field: 0 integer, 1..3 first to third order modulation.
// - spread follows a triangular profile through the fractional divider.
// - spread reaches only synthesizer clocks, never reference or pfd paths.
// - spread enable low means no modulation whatever the other fields.
// - spread type low gives downward spread, high gives centred spread.
// - select codes 0..3 pick detector rate and depth; 4..7 unused.
// - preset spread modulates at 31.5 kHz for a 100 MHz output.
// - each step adds or subtracts the 16-bit step size to numerator.
// - rising edge on up raises frequency; on down lowers it.
// - stepping enable bit off makes step requests ignored.
// - source bit picks pins or software bits as step triggers.
// - two software bits act as rising-edge step sources when selected.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module fpd_top (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pfdTick,
	input wire logic stepUpRequest,
	input wire logic stepDownRequest,
	output logic refDoubler_ff,
	output logic [7:0] referencePredivider_ff,
	output logic [15:0] feedbackDivide_ff,
	output logic [1:0] mashOrder_ff,
	output logic singleEndedPfd_ff,
	output logic fracLoopCfg_ff
);
	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP = 2'b10
	} fpd_wr_e;

	////////////////////////////////////////////////////////////////////////////
	// register storage
	fpd_wr_e wrState_ff;
	logic [15:0] stepCtrl_ff, refDiv_ff, mash_ff, fbInt_ff, numLo_ff, numHi_ff;
	logic [15:0] denLo_ff, denHi_ff, sscEn_ff, sscCfg_ff, stepSize_ff, loopCfg_ff;
	logic [11:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic awHeld_ff, wHeld_ff;
	logic [23:0] numLive_ff;
	logic [1:0] softLast_ff;

	function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] merged;
		merged = old;
		if (strb[0]) begin
			merged[7:0] = data[7:0];
		end
		if (strb[1]) begin
			merged[15:8] = data[15:8];
		end
		laneMerge = merged & mask;
	endfunction : laneMerge

	function automatic logic mapped(input logic [11:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) && (idx == fpd_pkg::IDX_STEP_CTRL
			|| idx == fpd_pkg::IDX_REF_DIV || idx == fpd_pkg::IDX_MASH || idx == fpd_pkg::IDX_FB_INT
			|| idx == fpd_pkg::IDX_NUM_LO || idx == fpd_pkg::IDX_NUM_HI || idx == fpd_pkg::IDX_DEN_LO
			|| idx == fpd_pkg::IDX_DEN_HI || idx == fpd_pkg::IDX_SSC_EN || idx == fpd_pkg::IDX_SSC_CFG
			|| idx == fpd_pkg::IDX_STEP_SIZE || idx == fpd_pkg::IDX_LOOP_CFG
			|| idx == fpd_pkg::IDX_LIVE_NUM_LO || idx == fpd_pkg::IDX_LIVE_NUM_HI
			|| idx == fpd_pkg::IDX_STATUS);
	endfunction : mapped

	////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order, then response
	wire awTake = s_axi_awvalid & s_axi_awready;
	wire wTake = s_axi_wvalid & s_axi_wready;
	wire doWrite = (wrState_ff == WR_COLLECT) & awHeld_ff & wHeld_ff;
	wire [7:0] wIdx = awAddr_ff[9:2];
	wire wOk = mapped(awAddr_ff);
	// registers update the edge after both halves are held
	// an unmapped index is answered with an error and changes nothing
	wire wNumLo = doWrite & wOk & (wIdx == fpd_pkg::IDX_NUM_LO);
	wire wNumHi = doWrite & wOk & (wIdx == fpd_pkg::IDX_NUM_HI);
	wire [15:0] nxt_numLo = laneMerge(numLo_ff, wData_ff, wStrb_ff, 16'hffff);
	wire [15:0] nxt_numHi = laneMerge(numHi_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_BYTE);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wrState_ff <= WR_COLLECT;
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fpd_pkg::AXI_OKAY;
		end else begin
			unique case (wrState_ff)
				WR_COLLECT: begin
					if (awTake) begin
						awAddr_ff <= s_axi_awaddr;
						awHeld_ff <= 1'b1;
						s_axi_awready <= 1'b0;
					end
					if (wTake) begin
						wData_ff <= s_axi_wdata;
						wStrb_ff <= s_axi_wstrb;
						wHeld_ff <= 1'b1;
						s_axi_wready <= 1'b0;
					end
					if (doWrite) begin
						wrState_ff <= WR_RESP;
						awHeld_ff <= 1'b0;
						wHeld_ff <= 1'b0;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wOk ? fpd_pkg::AXI_OKAY : fpd_pkg::AXI_SLVERR;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wrState_ff <= WR_COLLECT;
						s_axi_bvalid <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stepCtrl_ff <= fpd_pkg::RST_ZERO;
			refDiv_ff <= fpd_pkg::RST_REF_DIV;
			mash_ff <= fpd_pkg::RST_ZERO;
			fbInt_ff <= fpd_pkg::RST_FB_INT;
			numLo_ff <= fpd_pkg::RST_ZERO;
			numHi_ff <= fpd_pkg::RST_ZERO;
			denLo_ff <= fpd_pkg::RST_ZERO;
			denHi_ff <= fpd_pkg::RST_ZERO;
			sscEn_ff <= fpd_pkg::RST_ZERO;
			sscCfg_ff <= fpd_pkg::RST_ZERO;
			stepSize_ff <= fpd_pkg::RST_ZERO;
			loopCfg_ff <= fpd_pkg::RST_LOOP_CFG;
		end else if (doWrite && wOk) begin
			unique case (wIdx)
				fpd_pkg::IDX_STEP_CTRL: stepCtrl_ff <= laneMerge(stepCtrl_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_STEP_CTRL);
				fpd_pkg::IDX_REF_DIV: refDiv_ff <= laneMerge(refDiv_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_REF_DIV);
				fpd_pkg::IDX_MASH: mash_ff <= laneMerge(mash_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_MASH);
				fpd_pkg::IDX_FB_INT: fbInt_ff <= laneMerge(fbInt_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_FB_INT);
				fpd_pkg::IDX_NUM_LO: numLo_ff <= nxt_numLo;
				fpd_pkg::IDX_NUM_HI: numHi_ff <= nxt_numHi;
				fpd_pkg::IDX_DEN_LO: denLo_ff <= laneMerge(denLo_ff, wData_ff, wStrb_ff, 16'hffff);
				fpd_pkg::IDX_DEN_HI: denHi_ff <= laneMerge(denHi_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_BYTE);
				fpd_pkg::IDX_SSC_EN: sscEn_ff <= laneMerge(sscEn_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_SSC_EN);
				fpd_pkg::IDX_SSC_CFG: sscCfg_ff <= laneMerge(sscCfg_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_SSC_CFG);
				fpd_pkg::IDX_STEP_SIZE: stepSize_ff <= laneMerge(stepSize_ff, wData_ff, wStrb_ff, 16'hffff);
				fpd_pkg::IDX_LOOP_CFG: loopCfg_ff <= laneMerge(loopCfg_ff, wData_ff, wStrb_ff, fpd_pkg::MASK_LOOP_CFG);
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel: answer one cycle after the address is taken
	wire arTake = s_axi_arvalid & s_axi_arready;
	wire [7:0] rIdx = s_axi_araddr[9:2];
	logic [15:0] rWord;
	logic sscActive_ff;

	always_comb begin
		unique case (rIdx)
			fpd_pkg::IDX_STEP_CTRL: rWord = stepCtrl_ff;
			fpd_pkg::IDX_REF_DIV: rWord = refDiv_ff;
			fpd_pkg::IDX_MASH: rWord = mash_ff;
			fpd_pkg::IDX_FB_INT: rWord = fbInt_ff;
			fpd_pkg::IDX_NUM_LO: rWord = numLo_ff;
			fpd_pkg::IDX_NUM_HI: rWord = numHi_ff;
			fpd_pkg::IDX_DEN_LO: rWord = denLo_ff;
			fpd_pkg::IDX_DEN_HI: rWord = denHi_ff;
			fpd_pkg::IDX_SSC_EN: rWord = sscEn_ff;
			fpd_pkg::IDX_SSC_CFG: rWord = sscCfg_ff;
			fpd_pkg::IDX_STEP_SIZE: rWord = stepSize_ff;
			fpd_pkg::IDX_LOOP_CFG: rWord = loopCfg_ff;
			fpd_pkg::IDX_LIVE_NUM_LO: rWord = numLive_ff[15:0];
			fpd_pkg::IDX_LIVE_NUM_HI: rWord = {8'h00, numLive_ff[23:16]};
			fpd_pkg::IDX_STATUS: rWord = {15'h0000, sscActive_ff};
			default: rWord = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= fpd_pkg::AXI_OKAY;
		end else if (arTake) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= mapped(s_axi_araddr) ? {16'h0000, rWord} : 32'h00000000;
			s_axi_rresp <= mapped(s_axi_araddr) ? fpd_pkg::AXI_OKAY : fpd_pkg::AXI_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency stepping
	logic [1:0] pinRise;
	fpd_step_edge #(.W(2)) stepSync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.reqIn({stepDownRequest, stepUpRequest}),
		.risePulse(pinRise)
	);

	wire stepEnable = stepCtrl_ff[fpd_pkg::STEP_EN_BIT];
	wire softSource = stepCtrl_ff[fpd_pkg::STEP_SRC_BIT];
	wire [1:0] softBits = {stepCtrl_ff[fpd_pkg::SOFT_DN_BIT], stepCtrl_ff[fpd_pkg::SOFT_UP_BIT]};
	wire [1:0] softRise = softBits & ~softLast_ff;
	wire [1:0] stepRise = softSource ? softRise : pinRise;
	// simultaneous up and down cancel rather than race
	wire stepUp = stepEnable & stepRise[0] & ~stepRise[1];
	wire stepDown = stepEnable & stepRise[1] & ~stepRise[0];
	// a software write to the numerator reloads the live value and wins over a step
	wire [23:0] nxt_numLive = wNumLo ? {numHi_ff[7:0], nxt_numLo} : wNumHi ? {nxt_numHi[7:0], numLo_ff}
		: stepUp ? numLive_ff + {8'h00, stepSize_ff} : stepDown ? numLive_ff - {8'h00, stepSize_ff}
		: numLive_ff;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			softLast_ff <= 2'h0;
			numLive_ff <= 24'h000000;
		end else begin
			softLast_ff <= softBits;
			numLive_ff <= nxt_numLive;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// spread spectrum: triangular offset added to the live numerator
	wire [23:0] denField = {denHi_ff[7:0], denLo_ff};
	wire [24:0] denEff = (denField == 24'h000000) ? fpd_pkg::DEN_ZERO_VALUE : {1'b0, denField};
	wire [2:0] sscSel = sscCfg_ff[fpd_pkg::SSC_SEL_LSB +: 3];
	wire centerSpread = sscCfg_ff[fpd_pkg::SSC_TYPE_BIT];
	// unused select codes fall back to no modulation
	wire nxt_sscActive = sscEn_ff[fpd_pkg::SSC_EN_BIT] & ~sscSel[2];
	wire [10:0] halfPeriod = sscSel[1] ? fpd_pkg::HALF_HIGH : fpd_pkg::HALF_LOW;
	wire [8:0] spreadDiv = sscSel[0] ? fpd_pkg::SPREAD_HALF_DIV : fpd_pkg::SPREAD_QUARTER_DIV;
	// full ratio times denominator; the peak is truncated, fine for usual ratios
	wire [40:0] ratioScaled = 41'(fbInt_ff[14:0] * denEff) + {17'h00000, numLive_ff};
	wire [40:0] peakWide = ratioScaled / {32'h00000000, spreadDiv};
	logic [24:0] peak_ff;
	logic [10:0] triCount_ff;
	logic triDown_ff;
	logic signed [26:0] sscOffset_ff;
	wire [35:0] triScaled = 36'(peak_ff * triCount_ff) / {25'h0000000, halfPeriod};
	wire signed [26:0] rampPart = 27'(triScaled);
	wire signed [26:0] peakPart = {2'b00, peak_ff};
	wire signed [26:0] nxt_sscOffset = !sscActive_ff ? 27'sh0000000
		: centerSpread ? rampPart + rampPart - peakPart : -rampPart;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sscActive_ff <= 1'b0;
			peak_ff <= '0;
			triCount_ff <= '0;
			triDown_ff <= 1'b0;
			sscOffset_ff <= '0;
		end else begin
			sscActive_ff <= nxt_sscActive;
			peak_ff <= peakWide[24:0];
			sscOffset_ff <= nxt_sscOffset;
			if (!sscActive_ff) begin
				triCount_ff <= '0;
				triDown_ff <= 1'b0;
			end else if (pfdTick) begin
				// ramp up over one half period, then down over the next: one sweep at the modulation rate
				if (!triDown_ff && triCount_ff >= halfPeriod - 11'h001) begin
					triDown_ff <= 1'b1;
				end else if (triDown_ff && triCount_ff <= 11'h001) begin
					triDown_ff <= 1'b0;
				end
				triCount_ff <= triDown_ff ? triCount_ff - 11'h001 : triCount_ff + 11'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// modulator and divider outputs; reference/pfd routes never see the offset
	logic signed [3:0] sdmOffset;
	wire signed [26:0] modNum = $signed({3'b000, numLive_ff}) + sscOffset_ff;
	fpd_sdm #(.ACC_W(27)) modulator (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.pfdTick(pfdTick),
		.order(mash_ff[1:0]),
		.numIn(modNum),
		.denIn($signed({2'b00, denEff})),
		.divOffset(sdmOffset)
	);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			refDoubler_ff <= 1'b0;
			referencePredivider_ff <= '0;
			feedbackDivide_ff <= '0;
			mashOrder_ff <= '0;
			singleEndedPfd_ff <= 1'b0;
			fracLoopCfg_ff <= 1'b0;
		end else begin
			refDoubler_ff <= (refDiv_ff[7:0] == 8'h00);
			referencePredivider_ff <= refDiv_ff[7:0];
			feedbackDivide_ff <= {1'b0, fbInt_ff[14:0]} + {{12{sdmOffset[3]}}, sdmOffset};
			mashOrder_ff <= mash_ff[1:0];
			singleEndedPfd_ff <= loopCfg_ff[fpd_pkg::PFD_CFG_BIT];
			fracLoopCfg_ff <= loopCfg_ff[fpd_pkg::LOOP_CFG_BIT];
		end
	end
endmodule : fpd_top

/* File: verilog/fpd_pkg.sv */
// constants shared by the fractional synthesizer control block
// assumes a 250 MHz system clock and a 32-bit AXI4-Lite register port
package fpd_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STEP_CTRL = 8'h03;
	localparam logic [7:0] IDX_REF_DIV = 8'h19;
	localparam logic [7:0] IDX_MASH = 8'h1b;
	localparam logic [7:0] IDX_FB_INT = 8'h1e;
	localparam logic [7:0] IDX_NUM_LO = 8'h1f;
	localparam logic [7:0] IDX_NUM_HI = 8'h20;
	localparam logic [7:0] IDX_DEN_LO = 8'h21;
	localparam logic [7:0] IDX_DEN_HI = 8'h22;
	localparam logic [7:0] IDX_SSC_EN = 8'h29;
	localparam logic [7:0] IDX_SSC_CFG = 8'h2a;
	localparam logic [7:0] IDX_STEP_SIZE = 8'h2b;
	localparam logic [7:0] IDX_LOOP_CFG = 8'h33;
	localparam logic [7:0] IDX_LIVE_NUM_LO = 8'h80;
	localparam logic [7:0] IDX_LIVE_NUM_HI = 8'h81;
	localparam logic [7:0] IDX_STATUS = 8'h82;
	// field positions
	localparam int STEP_EN_BIT = 3;
	localparam int STEP_SRC_BIT = 4;
	localparam int SOFT_UP_BIT = 5;
	localparam int SOFT_DN_BIT = 6;
	localparam int SSC_EN_BIT = 15;
	localparam int SSC_TYPE_BIT = 5;
	localparam int SSC_SEL_LSB = 1;
	localparam int PFD_CFG_BIT = 6;
	localparam int LOOP_CFG_BIT = 10;
	// field masks for read-back, reserved bits read zero
	localparam logic [15:0] MASK_STEP_CTRL = 16'h0078;
	localparam logic [15:0] MASK_REF_DIV = 16'h00ff;
	localparam logic [15:0] MASK_MASH = 16'h0003;
	localparam logic [15:0] MASK_FB_INT = 16'h7fff;
	localparam logic [15:0] MASK_BYTE = 16'h00ff;
	localparam logic [15:0] MASK_SSC_EN = 16'h8000;
	localparam logic [15:0] MASK_SSC_CFG = 16'h002e;
	localparam logic [15:0] MASK_LOOP_CFG = 16'h0440;
	// reset values
	localparam logic [15:0] RST_REF_DIV = 16'h0001;
	localparam logic [15:0] RST_FB_INT = 16'h0030;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [15:0] RST_LOOP_CFG = 16'h0040;
	// spread spectrum timing, in pfd ticks
	localparam int MOD_RATE_HZ = 31500;
	localparam int PFD_LOW_HZ = 25000000;
	localparam int PFD_HIGH_HZ = 50000000;
	localparam logic [10:0] HALF_LOW = 11'(PFD_LOW_HZ / (2 * MOD_RATE_HZ));
	localparam logic [10:0] HALF_HIGH = 11'(PFD_HIGH_HZ / (2 * MOD_RATE_HZ));
	localparam logic [8:0] SPREAD_QUARTER_DIV = 9'h190;
	localparam logic [8:0] SPREAD_HALF_DIV = 9'h0c8;
	localparam logic [24:0] DEN_ZERO_VALUE = 25'h1000000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : fpd_pkg

/* File: verilog/fpd_step_edge.sv */
// synchroniser and rising-edge detector for the step request pins
// assumes each request level is held for at least three clk_sys cycles
`timescale 1ns/10ps
module fpd_step_edge #(
	parameter int W = 2
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [W-1:0] reqIn,
	output logic [W-1:0] risePulse
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] last_ff;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			sync_ff <= '0;
			last_ff <= '0;
		end else begin
			meta_ff <= reqIn;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign risePulse = sync_ff & ~last_ff;
endmodule : fpd_step_edge

/* File: verilog/fpd_sdm.sv */
// cascaded first/second/third order delta-sigma modulator
// assumes a one-cycle pfd tick and a numerator magnitude below the denominator
`timescale 1ns/10ps
module fpd_sdm #(
	parameter int ACC_W = 27
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic pfdTick,
	input wire logic [1:0] order,
	input wire logic signed [ACC_W-1:0] numIn,
	input wire logic signed [ACC_W-1:0] denIn,
	output logic signed [3:0] divOffset
);
	logic signed [ACC_W-1:0] acc1_ff, acc2_ff, acc3_ff;
	logic signed [1:0] c2d_ff, c3d_ff, c3dd_ff;
	logic [ACC_W+1:0] s1, s2, s3;
	logic signed [1:0] c1, c2, c3;
	logic signed [3:0] nxt_divOffset;

	// one correction per tick, so the input must stay within one modulus
	function automatic logic [ACC_W+1:0] accStep(input logic signed [ACC_W-1:0] acc,
			input logic signed [ACC_W-1:0] add, input logic signed [ACC_W-1:0] den);
		logic signed [ACC_W-1:0] sum;
		sum = acc + add;
		if (sum >= den) begin
			accStep = {2'sh1, ACC_W'(sum - den)};
		end else if (sum < 0) begin
			accStep = {2'sh3, ACC_W'(sum + den)};
		end else begin
			accStep = {2'sh0, sum};
		end
	endfunction : accStep

	assign s1 = accStep(acc1_ff, numIn, denIn);
	assign s2 = accStep(acc2_ff, s1[ACC_W-1:0], denIn);
	assign s3 = accStep(acc3_ff, s2[ACC_W-1:0], denIn);
	assign c1 = s1[ACC_W+1:ACC_W];
	assign c2 = s2[ACC_W+1:ACC_W];
	assign c3 = s3[ACC_W+1:ACC_W];

	// integer mode at order 0, noise shaping of order 1..3 otherwise
	always_comb begin
		unique case (order)
			2'h0: nxt_divOffset = 4'sh0;
			2'h1: nxt_divOffset = 4'(c1);
			2'h2: nxt_divOffset = 4'(c1) + 4'(c2) - 4'(c2d_ff);
			2'h3: nxt_divOffset = 4'(c1) + 4'(c2) - 4'(c2d_ff) + 4'(c3) - 4'(c3d_ff) - 4'(c3d_ff) + 4'(c3dd_ff);
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			acc1_ff <= '0;
			acc2_ff <= '0;
			acc3_ff <= '0;
			c2d_ff <= '0;
			c3d_ff <= '0;
			c3dd_ff <= '0;
			divOffset <= '0;
		end else if (pfdTick) begin
			acc1_ff <= s1[ACC_W-1:0];
			acc2_ff <= s2[ACC_W-1:0];
			acc3_ff <= s3[ACC_W-1:0];
			c2d_ff <= c2;
			c3d_ff <= c3;
			c3dd_ff <= c3d_ff;
			divOffset <= nxt_divOffset;
		end
	end
endmodule : fpd_sdm

/* File: tb/fpd_step_host.sv */
// stand-in for the external controller that pulses the step pins
// assumes one-cycle fire requests from the bench, clk_sys domain
`timescale 1ns/10ps
module fpd_step_host (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic fireUp,
	input wire logic fireDn,
	output logic stepUpRequest,
	output logic stepDownRequest
);
	logic [2:0] holdCnt;
	// level held four cycles, then low at least three before the next fire
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			holdCnt <= 3'h0;
			stepUpRequest <= 1'b0;
			stepDownRequest <= 1'b0;
		end else if (holdCnt != 3'h0) begin
			holdCnt <= holdCnt - 3'h1;
			if (holdCnt == 3'h4) begin
				stepUpRequest <= 1'b0;
				stepDownRequest <= 1'b0;
			end
		end else if (fireUp || fireDn) begin
			holdCnt <= 3'h7;
			stepUpRequest <= fireUp;
			stepDownRequest <= fireDn;
		end
	end
endmodule : fpd_step_host

/* File: tb/fpd_top_properties.sv */
// bus timing and divider flag checks on the fpd_top ports
// assumes a single clk_sys domain with asynchronous rst_b
`timescale 1ns/10ps
module fpd_top_properties (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic refDoubler_ff,
	input wire logic [7:0] referencePredivider_ff
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	a_doubler_zero: assert property ($past(rst_b) |-> refDoubler_ff == (referencePredivider_ff == 8'h00))
		else $error("doubler flag disagrees with predivider");
	a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("awready stayed high after take");
	a_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after take");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not rearmed after response");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one edge after ar take");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not rearmed after response");
endmodule : fpd_top_properties
bind fpd_top fpd_top_properties u_props (.clk_sys, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .refDoubler_ff, .referencePredivider_ff);

/* File: tb/fpd_top_tb.sv */
// self-checking bench for fpd_top: register rows, stepping, bus refusals
// assumes fpd_pkg, fpd_step_host and the checker are compiled first
`timescale 1ns/10ps
module fpd_top_tb;
	typedef struct {logic [7:0] idx; logic [15:0] wr; logic [15:0] rd;} fpd_row_s;
	logic clk_sys, rst_b, pfdTick, fireUp, fireDn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, mashOrder_ff, lastResp;
	logic stepUpRequest, stepDownRequest, refDoubler_ff, singleEndedPfd_ff, fracLoopCfg_ff;
	logic [7:0] referencePredivider_ff;
	logic [15:0] feedbackDivide_ff;
	int errTotal, numChecks;
	// write value beside expected read-back; reserved bits read zero
	fpd_row_s rows [10] = '{'{fpd_pkg::IDX_FB_INT, 16'hffff, 16'h7fff}, '{fpd_pkg::IDX_MASH, 16'h0007, 16'h0003},
		'{fpd_pkg::IDX_NUM_LO, 16'hfff0, 16'hfff0}, '{fpd_pkg::IDX_NUM_HI, 16'h01ff, 16'h00ff},
		'{fpd_pkg::IDX_DEN_LO, 16'h0250, 16'h0250}, '{fpd_pkg::IDX_DEN_HI, 16'h0100, 16'h0000},
		'{fpd_pkg::IDX_SSC_EN, 16'hffff, 16'h8000}, '{fpd_pkg::IDX_SSC_CFG, 16'hfff7, 16'h0026},
		'{fpd_pkg::IDX_STEP_SIZE, 16'h1234, 16'h1234}, '{fpd_pkg::IDX_LOOP_CFG, 16'hffbf, 16'h0400}};
	fpd_top u_dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pfdTick, .stepUpRequest,
		.stepDownRequest, .refDoubler_ff, .referencePredivider_ff, .feedbackDivide_ff, .mashOrder_ff,
		.singleEndedPfd_ff, .fracLoopCfg_ff);
	fpd_step_host u_host (.clk_sys, .rst_b, .fireUp, .fireDn, .stepUpRequest, .stepDownRequest);
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// lag holds the response ready low until the answer shows, to exercise its hold
	task automatic wr(input logic [7:0] idx, input logic [15:0] d, input bit lag = 1'b0);
		@(posedge clk_sys);
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !lag;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		lastResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(negedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input bit lag = 1'b0);
		@(posedge clk_sys);
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !lag;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		rdVal = s_axi_rdata;
		lastResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic live(input logic [23:0] e);
		rd(fpd_pkg::IDX_LIVE_NUM_LO);
		chk(rdVal, {16'h0000, e[15:0]});
		rd(fpd_pkg::IDX_LIVE_NUM_HI);
		chk(rdVal, {24'h000000, e[23:16]});
	endtask : live
	// wait covers sync, edge detect and the host's hold and gap
	task automatic pin(input logic up);
		@(posedge clk_sys);
		fireUp <= up;
		fireDn <= !up;
		@(posedge clk_sys);
		fireUp <= 1'b0;
		fireDn <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask : pin
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial begin
		#200000;
		errTotal++;
		end_sim();
	end
	initial begin
		{rst_b, pfdTick, fireUp, fireDn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 58'h0;
		s_axi_wstrb = 4'h3;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(fpd_pkg::IDX_REF_DIV);
		chk(rdVal, 32'h1);
		chk({23'h0, refDoubler_ff, referencePredivider_ff}, 32'h1);
		chk({31'h0, singleEndedPfd_ff}, 32'h1);
		rd(fpd_pkg::IDX_FB_INT);
		chk(rdVal, 32'h30);
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wr);
			rd(rows[i].idx);
			chk(rdVal, {16'h0000, rows[i].rd});
		end
		chk({28'h0, mashOrder_ff, fracLoopCfg_ff, singleEndedPfd_ff}, 32'he);
		rd(fpd_pkg::IDX_STATUS);
		chk(rdVal, 32'h1);
		wr(fpd_pkg::IDX_REF_DIV, 16'h0000);
		chk({23'h0, refDoubler_ff, referencePredivider_ff}, 32'h100);
		wr(fpd_pkg::IDX_REF_DIV, 16'h0005);
		chk({23'h0, refDoubler_ff, referencePredivider_ff}, 32'h5);
		wr(fpd_pkg::IDX_SSC_EN, 16'h0000);
		rd(fpd_pkg::IDX_STATUS);
		chk(rdVal, 32'h0);
		wr(fpd_pkg::IDX_MASH, 16'h0000);
		wr(fpd_pkg::IDX_LOOP_CFG, 16'h0040);
		chk({30'h0, fracLoopCfg_ff, singleEndedPfd_ff}, 32'h1);
		@(posedge clk_sys);
		pfdTick <= 1'b1;
		@(posedge clk_sys);
		pfdTick <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk({16'h0, feedbackDivide_ff}, 32'h7fff);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0008);
		pin(1'b1);
		live(24'h001224);
		pin(1'b0);
		live(24'hfffff0);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0000);
		pin(1'b1);
		live(24'hfffff0);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0018);
		pin(1'b1);
		live(24'hfffff0);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0038);
		live(24'h001224);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0018);
		wr(fpd_pkg::IDX_STEP_CTRL, 16'h0058);
		live(24'hfffff0);
		wr(8'h40, 16'hffff, 1'b1);
		chk({30'h0, lastResp}, {30'h0, fpd_pkg::AXI_SLVERR});
		rd(8'h40, 1'b1);
		chk(rdVal, 32'h0);
		chk({30'h0, lastResp}, {30'h0, fpd_pkg::AXI_SLVERR});
		end_sim();
	end
endmodule : fpd_top_tb
